// *** rtl/fan_fault_ctrl.sv ***
// Fan fault latching, masking and alert with an AXI4-Lite register slave
//
// Operation
// RL1 - Six fault bits per bank, two banks
// RL2 - Detected fault sets the fan's status bit
// RL3 - Bit latches until target duty/count write
// RL4 - Upper bank only for pins used as tachometer_input
// RL5 - Mask one blocks alert, zero allows it
// RL6 - Masked faults still latch in status
// RL7 - Failed fan drive follows failed-fan options
// RL8 - Alert while any unmasked status bit set
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module fan_fault_ctrl (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Fault detection, one-cycle or level, same clock
    input  wire logic [5:0]  fault_detect_lower,
    input  wire logic [5:0]  fault_detect_upper,
    // Target duty or tachometer_input count written, one pulse per fan
    input  wire logic [5:0]  target_write_lower,
    input  wire logic [5:0]  target_write_upper,
    // Pulse width output pins configured as tachometer inputs
    input  wire logic [5:0]  tachometer_input_mode_upper,
    // Failed fans, to the failed-fan options logic
    output logic [5:0]       fan_failed_lower,
    output logic [5:0]       fan_failed_upper,
    // Open-drain fan-fail alert pin
    input  wire logic        fan_fail_in,
    output logic             fan_fail_out,
    output logic             fan_fail_oe,
    // Interrupt
    output logic             irq
);

    // ************************************************************
    // Fault latch banks
    // ************************************************************
    fault_bank_if #(.N(fan_fault_pkg::FANS_PER_BANK)) lower_if ();
    fault_bank_if #(.N(fan_fault_pkg::FANS_PER_BANK)) upper_if ();

    fault_latch_bank u_lower (
        .sys_clk (sys_clk),
        .reset   (reset),
        .b       (lower_if)
    );

    fault_latch_bank u_upper (
        .sys_clk (sys_clk),
        .reset   (reset),
        .b       (upper_if)
    );

    assign lower_if.detect = fault_detect_lower;
    assign upper_if.detect = fault_detect_upper;
    assign lower_if.enable = 6'h3f;
    // Unused tachometer_input pins must not invent faults
    assign upper_if.enable = tachometer_input_mode_upper; // RL4
    assign lower_if.clear  = target_write_lower; // RL3
    assign upper_if.clear  = target_write_upper; // RL3

    // ************************************************************
    // Pin synchroniser
    // ************************************************************
    logic fan_fail_pin_s;

    sync_2ff #(.W(1)) u_pin_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in (fan_fail_in),
        .sync_out (fan_fail_pin_s)
    );

    // ************************************************************
    // Registers
    // ************************************************************
    logic [5:0]  mask_lower_r;
    logic [5:0]  mask_upper_r;
    logic [11:0] irq_status_r;
    logic [11:0] irq_enable_r;
    logic        alert_r;

    // ************************************************************
    // Write channel capture
    // ************************************************************
    logic        aw_full_r;
    logic [5:0]  aw_idx_r;
    logic        w_full_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        wr_fire;
    logic        wr_hit;

    // Both halves held and no answer pending
    assign wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            aw_full_r     <= 1'b0;
            aw_idx_r      <= 6'h00;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r     <= 1'b1;
            aw_idx_r      <= s_axi_awaddr[7:2];
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_full_r     <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            w_full_r     <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_r     <= 1'b1;
            w_data_r     <= s_axi_wdata;
            w_strb_r     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_full_r     <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // ************************************************************
    // Write decode
    // ************************************************************
    logic wr_mask_lower;
    logic wr_mask_upper;
    logic wr_irq_clear;
    logic wr_irq_enable;

    always_comb begin
        wr_mask_lower = 1'b0;
        wr_mask_upper = 1'b0;
        wr_irq_clear  = 1'b0;
        wr_irq_enable = 1'b0;
        wr_hit        = 1'b1;
        case (aw_idx_r)
            fan_fault_pkg::IDX_MASK_LOWER[5:0]:   wr_mask_lower = wr_fire;
            fan_fault_pkg::IDX_MASK_UPPER[5:0]:   wr_mask_upper = wr_fire;
            fan_fault_pkg::IDX_IRQ_CLEAR[5:0]:    wr_irq_clear  = wr_fire;
            fan_fault_pkg::IDX_IRQ_ENABLE[5:0]:   wr_irq_enable = wr_fire;
            // Fan status can only be cleared through target writes, interrupt status through the clear register
            fan_fault_pkg::IDX_STATUS_LOWER[5:0]: wr_hit        = 1'b1;
            fan_fault_pkg::IDX_STATUS_UPPER[5:0]: wr_hit        = 1'b1;
            fan_fault_pkg::IDX_IRQ_STATUS[5:0]:   wr_hit        = 1'b1;
            fan_fault_pkg::IDX_ALERT_STATE[5:0]:  wr_hit        = 1'b1;
            default:                              wr_hit        = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= fan_fault_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? fan_fault_pkg::RESP_OKAY : fan_fault_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Mask registers
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mask_lower_r <= fan_fault_pkg::RST_MASK[5:0];
        end else if (wr_mask_lower && w_strb_r[0]) begin
            mask_lower_r <= w_data_r[fan_fault_pkg::FAULT_MSB:fan_fault_pkg::FAULT_LSB];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mask_upper_r <= fan_fault_pkg::RST_MASK[5:0];
        end else if (wr_mask_upper && w_strb_r[0]) begin
            mask_upper_r <= w_data_r[fan_fault_pkg::FAULT_MSB:fan_fault_pkg::FAULT_LSB];
        end
    end

    // ************************************************************
    // Interrupt status, enable and clear
    // ************************************************************
    logic [11:0] irq_set;
    logic [11:0] irq_clr;
    logic [11:0] irq_status_nxt;

    assign irq_set = {upper_if.fresh, lower_if.fresh};
    assign irq_clr = (wr_irq_clear && (w_strb_r[1:0] == 2'h3)) ? w_data_r[11:0] : 12'h000;
    // Set wins so an event in the clearing cycle survives
    assign irq_status_nxt = (irq_status_r & ~irq_clr) | irq_set;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_status_r <= 12'h000;
        end else begin
            irq_status_r <= irq_status_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_enable_r <= fan_fault_pkg::RST_IRQ_ENABLE;
        end else if (wr_irq_enable && (w_strb_r[1:0] == 2'h3)) begin
            irq_enable_r <= w_data_r[11:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_r & irq_enable_r);
        end
    end

    // ************************************************************
    // Fan-fail alert
    // ************************************************************
    logic [5:0] alert_lower;
    logic [5:0] alert_upper;

    assign alert_lower = lower_if.status & ~mask_lower_r; // RL5 RL6
    assign alert_upper = upper_if.status & ~mask_upper_r & tachometer_input_mode_upper; // RL4 RL5

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            alert_r <= 1'b0;
        end else begin
            alert_r <= |{alert_upper, alert_lower}; // RL8
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fan_fail_out <= 1'b0;
            fan_fail_oe  <= 1'b0;
        end else begin
            fan_fail_out <= 1'b0;
            fan_fail_oe  <= |{alert_upper, alert_lower}; // RL8
        end
    end

    // ************************************************************
    // Failed fan report
    // ************************************************************
    // Mask plays no part here, drive comes from failed-fan options
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fan_failed_lower <= 6'h00;
            fan_failed_upper <= 6'h00;
        end else begin
            fan_failed_lower <= lower_if.status; // RL7
            fan_failed_upper <= upper_if.status & tachometer_input_mode_upper; // RL7
        end
    end

    // ************************************************************
    // Read channel
    // ************************************************************
    logic [31:0] rd_data;
    logic        rd_hit;

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr[7:2])
            fan_fault_pkg::IDX_STATUS_LOWER[5:0]: rd_data[5:0] = lower_if.status; // RL1
            fan_fault_pkg::IDX_STATUS_UPPER[5:0]: rd_data[5:0] = upper_if.status; // RL1
            fan_fault_pkg::IDX_MASK_LOWER[5:0]:   rd_data[5:0] = mask_lower_r;
            fan_fault_pkg::IDX_MASK_UPPER[5:0]:   rd_data[5:0] = mask_upper_r;
            fan_fault_pkg::IDX_IRQ_STATUS[5:0]:   rd_data[11:0] = irq_status_r;
            fan_fault_pkg::IDX_IRQ_ENABLE[5:0]:   rd_data[11:0] = irq_enable_r;
            // Clear register is write-only
            fan_fault_pkg::IDX_IRQ_CLEAR[5:0]:    rd_data = 32'h0000_0000;
            fan_fault_pkg::IDX_ALERT_STATE[5:0]: begin
                rd_data[fan_fault_pkg::ALERT_BIT] = alert_r;
                rd_data[fan_fault_pkg::PIN_BIT]   = fan_fail_pin_s;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= fan_fault_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_hit ? fan_fault_pkg::RESP_OKAY : fan_fault_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

endmodule

// *** rtl/fan_fault_pkg.sv ***
// Package with register map, reset values and field layout of the fan fault block
package fan_fault_pkg;

    // ************************************************************
    // Field layout
    // ************************************************************
    localparam int FANS_PER_BANK = 6;
    localparam int FAULT_LSB     = 0;
    localparam int FAULT_MSB     = 5;
    localparam int IRQ_LOWER_LSB = 0;
    localparam int IRQ_UPPER_LSB = 6;
    localparam int IRQ_WIDTH     = 12;
    localparam int ALERT_BIT     = 0;
    localparam int PIN_BIT       = 1;

    // ************************************************************
    // Register indices, byte address is four times the index
    // ************************************************************
    localparam logic [7:0] IDX_STATUS_UPPER = 8'h10;
    localparam logic [7:0] IDX_STATUS_LOWER = 8'h11;
    localparam logic [7:0] IDX_MASK_UPPER   = 8'h12;
    localparam logic [7:0] IDX_MASK_LOWER   = 8'h13;
    localparam logic [7:0] IDX_IRQ_STATUS   = 8'h20;
    localparam logic [7:0] IDX_IRQ_CLEAR    = 8'h21;
    localparam logic [7:0] IDX_IRQ_ENABLE   = 8'h22;
    localparam logic [7:0] IDX_ALERT_STATE  = 8'h23;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [7:0]  RST_STATUS     = 8'h00;
    localparam logic [7:0]  RST_MASK       = 8'h3f;
    localparam logic [11:0] RST_IRQ_ENABLE = 12'h000;

    // ************************************************************
    // Bus answers
    // ************************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** rtl/fault_bank_if.sv ***
// Interface carrying one bank of six fault latches between top and latch bank
`timescale 1ns/1ps
interface fault_bank_if #(
    parameter int N = 6
);
    logic [N-1:0] detect;
    logic [N-1:0] enable;
    logic [N-1:0] clear;
    logic [N-1:0] status;
    logic [N-1:0] fresh;

    modport ctl  (output detect, output enable, output clear, input status, input fresh);
    modport bank (input detect, input enable, input clear, output status, output fresh);
endinterface

// *** rtl/sync_2ff.sv ***
// Two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module sync_2ff #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// *** rtl/fault_latch_bank.sv ***
// Bank of sticky per-fan fault latches
`timescale 1ns/1ps
module fault_latch_bank (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // Bank signals
    fault_bank_if.bank b
);
    logic [$bits(b.status)-1:0] status_r;

    // Newly detected faults, for the interrupt status
    assign b.fresh  = b.detect & b.enable & ~status_r;
    assign b.status = status_r;

    // Set wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~b.clear) | (b.detect & b.enable); // RL2 RL3 RL6
        end
    end
endmodule

// *** dv/fan_fault_ctrl_properties.sv ***
// Checker of fault latching, alert and bus timing at the block's ports
`timescale 1ns/1ps
module fan_fault_ctrl_properties (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset,
    // Bus handshakes
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    // Fault side
    input wire logic [5:0]  fault_detect_lower,
    input wire logic [5:0]  fault_detect_upper,
    input wire logic [5:0]  target_write_lower,
    input wire logic [5:0]  target_write_upper,
    input wire logic [5:0]  tachometer_input_mode_upper,
    input wire logic [5:0]  fan_failed_lower,
    input wire logic [5:0]  fan_failed_upper,
    input wire logic        fan_fail_out,
    input wire logic        fan_fail_oe
);
    // ****************************************
    // Properties
    // ****************************************
    logic [5:0] det_up_en;
    assign det_up_en = fault_detect_upper & tachometer_input_mode_upper;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_set_lower;
        (fault_detect_lower != 6'h00) ##1 (target_write_lower == 6'h00) |=>
            (fan_failed_lower & $past(fault_detect_lower, 2)) == $past(fault_detect_lower, 2);
    endproperty
    a_set_lower: assert property (p_set_lower) else $error("lower fault not latched");
    property p_set_upper;
        (det_up_en != 6'h00) ##1 (target_write_upper == 6'h00 && $stable(tachometer_input_mode_upper)) |=>
            (fan_failed_upper & $past(det_up_en, 2)) == $past(det_up_en, 2);
    endproperty
    a_set_upper: assert property (p_set_upper) else $error("upper fault not latched");
    // A lower-bank drop is legal only two edges after that fan's target write
    property p_sticky;
        ((~fan_failed_lower & $past(fan_failed_lower)) & ~$past(target_write_lower, 2)) == 6'h00;
    endproperty
    a_sticky: assert property (p_sticky) else $error("fault bit dropped unasked");
    property p_gate;
        $stable(tachometer_input_mode_upper) [*3] |-> (fan_failed_upper & ~tachometer_input_mode_upper) == 6'h00;
    endproperty
    a_gate: assert property (p_gate) else $error("fault on a non-tachometer_input pin");
    property p_alert_cause;
        fan_fail_oe |-> (fan_failed_lower | fan_failed_upper) != 6'h00;
    endproperty
    a_alert_cause: assert property (p_alert_cause) else $error("alert without a fault");
    property p_pin_low;
        fan_fail_out == 1'b0;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("alert pin driven high");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response not held");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
    property p_rlat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
endmodule

// *** dv/fan_alert_host_model.sv ***
// Pull-up and host sense of the open-drain fan-fail alert line
`timescale 1ns/1ps
module fan_alert_host_model (
    // Pin drive from the block
    input  wire logic fan_fail_oe,
    input  wire logic fan_fail_out,
    // Line level fed back to the pin input
    output logic      fan_fail_in
);
    // Released line is pulled up, never left at its last value
    assign fan_fail_in = fan_fail_oe ? fan_fail_out : 1'b1;
endmodule

// *** dv/fan_fault_ctrl_tb.sv ***
// Self-checking bench of the fan fault block
`timescale 1ns/1ps
module fan_fault_ctrl_tb;
    logic        sys_clk, reset, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [5:0]  fault_detect_lower, fault_detect_upper, target_write_lower, target_write_upper;
    logic [5:0]  tachometer_input_mode_upper, fan_failed_lower, fan_failed_upper, v, c, u;
    logic        fan_fail_in, fan_fail_out, fan_fail_oe;
    int          num_errors = 0;
    int          num_checks = 0;
    integer      seed = 32'ha6a3ec91;
    logic [33:0] rd_q[$];
    logic [1:0]  wr_q[$];

    fan_fault_ctrl i_fan_fault_ctrl (.sys_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fault_detect_lower,
        .fault_detect_upper, .target_write_lower, .target_write_upper, .tachometer_input_mode_upper,
        .fan_failed_lower, .fan_failed_upper, .fan_fail_in, .fan_fail_out, .fan_fail_oe, .irq);
    fan_alert_host_model i_fan_alert_host_model (.fan_fail_oe, .fan_fail_out, .fan_fail_in);

    // ****************************************
    // Compare and bus tasks
    // ****************************************
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected resp at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Ready comes late so the slave must hold its answer
    task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        wr_q.push_back(er);
        s_axi_awaddr  <= {idx[5:0], 2'b00};
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (n == 2) s_axi_bready <= 1'b1;
            n++;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
        int n = 0;
        rd_q.push_back({er, ed});
        s_axi_araddr  <= {idx[5:0], 2'b00};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (n == 2) s_axi_rready <= 1'b1;
            n++;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
    endtask
    task automatic hit(input logic [5:0] dl, input logic [5:0] du, input logic [5:0] cl,
                       input logic [5:0] cu);
        fault_detect_lower <= dl;
        fault_detect_upper <= du;
        target_write_lower <= cl;
        target_write_upper <= cu;
        @(posedge sys_clk);
        fault_detect_lower <= 6'h00;
        fault_detect_upper <= 6'h00;
        target_write_lower <= 6'h00;
        target_write_upper <= 6'h00;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Result watcher, clock, watchdog
    // ****************************************
    always @(posedge sys_clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            cmp_word(s_axi_rdata, rd_q[0][31:0]);
            cmp_resp(s_axi_rresp, rd_q[0][33:32]);
            void'(rd_q.pop_front());
        end
        if (s_axi_bvalid && s_axi_bready) cmp_resp(s_axi_bresp, wr_q.pop_front());
    end
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        tally_and_finish();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        {fault_detect_lower, fault_detect_upper, target_write_lower, target_write_upper} = 24'h0;
        tachometer_input_mode_upper = 6'h0f;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd(fan_fault_pkg::IDX_STATUS_UPPER, 32'h0, fan_fault_pkg::RESP_OKAY);
        rd(fan_fault_pkg::IDX_MASK_UPPER, 32'h3f, fan_fault_pkg::RESP_OKAY);
        rd(fan_fault_pkg::IDX_ALERT_STATE, 32'h2, fan_fault_pkg::RESP_OKAY);
        rd(8'h30, 32'h0, fan_fault_pkg::RESP_SLVERR);
        wr(8'h30, 32'h0, fan_fault_pkg::RESP_SLVERR);
        // Masked faults latch but stay silent
        v = 6'($random(seed)) | 6'h01;
        c = 6'($random(seed));
        u = 6'($random(seed));
        hit(v, u, 6'h00, 6'h00);
        rd(fan_fault_pkg::IDX_STATUS_LOWER, {26'h0, v}, fan_fault_pkg::RESP_OKAY);
        rd(fan_fault_pkg::IDX_STATUS_UPPER, {26'h0, u & 6'h0f}, fan_fault_pkg::RESP_OKAY);
        rd(fan_fault_pkg::IDX_ALERT_STATE, 32'h2, fan_fault_pkg::RESP_OKAY);
        wr(fan_fault_pkg::IDX_STATUS_LOWER, 32'h0, fan_fault_pkg::RESP_OKAY);
        hit(6'h00, 6'h00, c, 6'h00);
        rd(fan_fault_pkg::IDX_STATUS_LOWER, {26'h0, v & ~c}, fan_fault_pkg::RESP_OKAY);
        // Unmasking lets a latched fault reach the pin
        wr(fan_fault_pkg::IDX_MASK_LOWER, 32'h0, fan_fault_pkg::RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        rd(fan_fault_pkg::IDX_ALERT_STATE, ((v & ~c) != 6'h00) ? 32'h1 : 32'h2, 2'h0);
        hit(6'h00, 6'h00, 6'h3f, 6'h3f);
        rd(fan_fault_pkg::IDX_ALERT_STATE, 32'h2, fan_fault_pkg::RESP_OKAY);
        wr(fan_fault_pkg::IDX_MASK_UPPER, 32'h0, fan_fault_pkg::RESP_OKAY);
        hit(6'h00, 6'h30, 6'h00, 6'h00);
        rd(fan_fault_pkg::IDX_ALERT_STATE, 32'h2, fan_fault_pkg::RESP_OKAY);
        hit(6'h00, 6'h04, 6'h00, 6'h00);
        rd(fan_fault_pkg::IDX_ALERT_STATE, 32'h1, fan_fault_pkg::RESP_OKAY);
        wr(fan_fault_pkg::IDX_MASK_UPPER, 32'h3f, fan_fault_pkg::RESP_OKAY);
        rd(fan_fault_pkg::IDX_STATUS_UPPER, 32'h4, fan_fault_pkg::RESP_OKAY);
        hit(6'h00, 6'h00, 6'h00, 6'h04);
        // Interrupt raised, masked and cleared
        wr(fan_fault_pkg::IDX_IRQ_CLEAR, 32'hfff, fan_fault_pkg::RESP_OKAY);
        wr(fan_fault_pkg::IDX_IRQ_ENABLE, 32'hfff, fan_fault_pkg::RESP_OKAY);
        hit(6'h04, 6'h00, 6'h00, 6'h00);
        cmp_word({31'h0, irq}, 32'h1);
        rd(fan_fault_pkg::IDX_IRQ_STATUS, 32'h4, fan_fault_pkg::RESP_OKAY);
        wr(fan_fault_pkg::IDX_IRQ_ENABLE, 32'h0, fan_fault_pkg::RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        cmp_word({31'h0, irq}, 32'h0);
        wr(fan_fault_pkg::IDX_IRQ_ENABLE, 32'hfff, fan_fault_pkg::RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        cmp_word({31'h0, irq}, 32'h1);
        wr(fan_fault_pkg::IDX_IRQ_CLEAR, 32'h4, fan_fault_pkg::RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        cmp_word({31'h0, irq}, 32'h0);
        // Set and clear in one cycle: the set must win
        hit(6'h01, 6'h00, 6'h01, 6'h00);
        rd(fan_fault_pkg::IDX_STATUS_LOWER, 32'h5, fan_fault_pkg::RESP_OKAY);
        // Second reset in mid-run
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd(fan_fault_pkg::IDX_STATUS_LOWER, 32'h0, fan_fault_pkg::RESP_OKAY);
        rd(fan_fault_pkg::IDX_MASK_LOWER, 32'h3f, fan_fault_pkg::RESP_OKAY);
        repeat (4) @(posedge sys_clk);
        tally_and_finish();
    end
endmodule

bind fan_fault_ctrl fan_fault_ctrl_properties i_fan_fault_ctrl_properties (.sys_clk, .reset,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .fault_detect_lower, .fault_detect_upper, .target_write_lower,
    .target_write_upper, .tachometer_input_mode_upper, .fan_failed_lower, .fan_failed_upper, .fan_fail_out,
    .fan_fail_oe);
